// ==== verilog/modem_flow_pkg.sv ====
// Shared register map, field positions, reset values and trigger levels
`default_nettype none

package modem_flow_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_MODEM_LINE_STATE = 8'h00;
	localparam logic [7:0] OFF_SCRATCH_BYTE     = 8'h04;
	localparam logic [7:0] OFF_ENH_FEATURE      = 8'h08;
	localparam logic [7:0] OFF_LINE_CONTROL     = 8'h0C;
	localparam logic [7:0] OFF_IRQ_STATUS       = 8'h10;
	localparam logic [7:0] OFF_IRQ_CLEAR        = 8'h14;
	localparam logic [7:0] OFF_IRQ_ENABLE       = 8'h18;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int EFR_AUTO_CTS_BIT = 7;
	localparam int EFR_AUTO_RTS_BIT = 6;
	localparam int EFR_SPECIAL_BIT  = 5;
	localparam int EFR_FLOW_MSB     = 4;
	localparam int EFR_TX_DUAL_HI   = 3;
	localparam int EFR_TX_DUAL_LO   = 2;
	localparam int EFR_RX_DUAL_HI   = 1;
	localparam int EFR_RX_DUAL_LO   = 0;
	localparam int CTL_RTS_BIT      = 0;
	localparam int CTL_TRIG_LSB     = 1;
	localparam int IRQ_MODEM_BIT    = 0;
	localparam int IRQ_RX_TRIG_BIT  = 1;
	localparam int IRQ_W            = 2;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]       RST_SCRATCH  = 8'h00;
	localparam logic [7:0]       RST_ENH      = 8'h00;
	localparam logic [2:0]       RST_CONTROL  = 3'h0;
	localparam logic [IRQ_W-1:0] RST_IRQ_EN   = 2'h0;

	// ----------------------------------------------------------------
	// Bus answers and receive trigger levels, index 0 lowest
	// ----------------------------------------------------------------
	localparam logic [1:0]      RESP_OKAY   = 2'h0;
	localparam logic [1:0]      RESP_SLVERR = 2'h2;
	localparam logic [3:0][7:0] TRIG_LEVELS = {8'h1C, 8'h18, 8'h10, 8'h08};

endpackage

`default_nettype wire

// ==== verilog/line_change_det.sv ====
// Synchroniser and change detector for one active-low modem input
`default_nettype none

module line_change_det #(
	parameter bit RISE_ONLY = 1'b0
) (
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Pin and results
	input  wire logic pin_n,
	output var  logic active_q,
	output var  logic change
);

	logic meta_q;
	logic sync_q;

	// ----------------------------------------------------------------
	// Two-stage synchroniser, idle level high
	// ----------------------------------------------------------------
	// sync before edge detect
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_q <= 1'b1;
			sync_q <= 1'b1;
		end else begin
			meta_q <= pin_n;
			sync_q <= meta_q;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			active_q <= 1'b0;
		end else begin
			active_q <= ~sync_q;
		end
	end

	// One pulse per settled change, or per settled rise of the pin only when RISE_ONLY
	always_comb begin
		if (RISE_ONLY) begin
			change = sync_q & active_q;
		end else begin
			change = sync_q == active_q;
		end
	end

endmodule

`default_nettype wire

// ==== verilog/rts_throttle.sv ====
// Automatic RTS hysteresis around the receive trigger levels
`default_nettype none

module rts_throttle
	import modem_flow_pkg::*;
#(
	parameter int FIFO_DEPTH = 32,
	parameter int LVL_W      = 6
) (
	// Clock and reset
	input  wire logic             aclk,
	input  wire logic             aresetn,
	// Control and level
	input  wire logic             enable,
	input  wire logic [1:0]       trig_sel,
	input  wire logic [LVL_W-1:0] rx_level,
	output var  logic             throttle_q
);

	logic [7:0] hi;
	logic [7:0] lo;
	logic [7:0] level8;

	// Levels are compared as bytes
	if (FIFO_DEPTH < 1 || FIFO_DEPTH > 255 || LVL_W > 8) begin : g_bad_cfg
		$error("FIFO_DEPTH must fit 8 bits and LVL_W at most 8");
	end

	// ----------------------------------------------------------------
	// Next level above and next level below the programmed one
	// ----------------------------------------------------------------
	always_comb begin
		hi     = 8'(FIFO_DEPTH);
		lo     = 8'h01;
		level8 = 8'(rx_level);
		if (trig_sel != 2'h3) begin
			hi = TRIG_LEVELS[trig_sel + 2'h1];
		end
		if (trig_sel != 2'h0) begin
			lo = TRIG_LEVELS[trig_sel - 2'h1];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			throttle_q <= 1'b0;
		end else if (!enable) begin
			throttle_q <= 1'b0;
		end else if (level8 >= hi) begin
			throttle_q <= 1'b1;
		end else if (level8 < lo) begin
			throttle_q <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// ==== verilog/modem_status_flow_control.sv ====
// Modem status change flags, scratch byte and hardware flow control
//
// Behaviour
// - DSR change sets status bit 1, interrupt
// - CTS change sets status bit 0, interrupt
// - Modem interrupt while any flag 0-3 set
// - Reading modem status clears change flags
// - Eight-bit scratch byte reads back last write
// - Low five bits pick single/dual characters
// - Bit 7: CTS high halts, low resumes
// - Current character finishes before halt
// - Auto CTS off after reset
// - Bit 6: interrupt at programmed trigger level
// - Auto RTS raises RTS at next level
// - Auto RTS drops RTS below lower level
// - Auto RTS off: RTS follows control bit
// - Auto RTS off after reset
// - Bit 6 readback tracks flow control state; the register reads back the written enable bit instead
//
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`default_nettype none

module modem_status_flow_control
	import modem_flow_pkg::*;
#(
	parameter int ADDR_W     = 8,
	parameter int FIFO_DEPTH = 32,
	parameter int LVL_W      = $clog2(FIFO_DEPTH + 1)
) (
	// Clock and reset
	input  wire logic             aclk,
	input  wire logic             aresetn,
	// AXI4-Lite write channels
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic             awvalid,
	output var  logic             awready,
	input  wire logic [31:0]      wdata,
	input  wire logic [3:0]       wstrb,
	input  wire logic             wvalid,
	output var  logic             wready,
	output var  logic [1:0]       bresp,
	output var  logic             bvalid,
	input  wire logic             bready,
	// AXI4-Lite read channels
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic             arvalid,
	output var  logic             arready,
	output var  logic [31:0]      rdata,
	output var  logic [1:0]       rresp,
	output var  logic             rvalid,
	input  wire logic             rready,
	// Modem handshake pins, active low
	input  wire logic             cts_n,
	input  wire logic             dsr_n,
	input  wire logic             dcd_n,
	input  wire logic             ri_n,
	output var  logic             rts_n,
	// Transmitter and receive FIFO side
	input  wire logic             tx_char_active,
	output var  logic             tx_pause,
	input  wire logic [LVL_W-1:0] rx_level,
	output var  logic             rx_trigger_irq,
	// Software flow-control selection
	output var  logic [4:0]       flow_select,
	output var  logic             dual_tx_chars,
	output var  logic             dual_rx_chars,
	// Interrupts
	output var  logic             modem_irq,
	output var  logic             irq
);

	// ----------------------------------------------------------------
	// Parameter checks
	// ----------------------------------------------------------------
	if (ADDR_W < 5 || ADDR_W > 32) begin : g_bad_addr
		$error("ADDR_W must lie between 5 and 32");
	end
	if (FIFO_DEPTH <= int'(TRIG_LEVELS[3]) || FIFO_DEPTH > 255) begin : g_bad_depth
		$error("FIFO_DEPTH must exceed the top trigger level and fit 8 bits");
	end
	if (LVL_W != $clog2(FIFO_DEPTH + 1)) begin : g_bad_lvl
		$error("LVL_W must match FIFO_DEPTH");
	end

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [ADDR_W-1:0] aw_addr_q;
	logic [31:0]       w_data_q;
	logic              w_strb0_q;
	logic              aw_full_q;
	logic              w_full_q;
	logic              do_write;
	logic              aw_full_d;
	logic              w_full_d;
	logic              ar_take;
	logic [7:0]        wr_off;
	logic [7:0]        rd_off;
	logic              wr_en;
	logic              wr_hit;
	logic              rd_hit;
	logic [31:0]       rd_value;
	logic              msr_read;

	logic [7:0]           scratch_q;
	logic [7:0]           enh_q;
	logic [2:0]           control_q;
	logic [IRQ_W-1:0]     irq_en_q;
	logic [IRQ_W-1:0]     irq_stat_q;
	logic [IRQ_W-1:0]     irq_clr;
	logic [IRQ_W-1:0]     irq_evt;
	logic [3:0]           flags_q;
	logic [3:0]           line_state;
	logic [3:0]           line_chg;
	logic                 trig_hit;
	logic                 trig_hit_q;
	logic                 throttle_q;

	// ----------------------------------------------------------------
	// Modem input detectors: 0 CTS, 1 DSR, 2 RI, 3 DCD
	// ----------------------------------------------------------------
	line_change_det #(.RISE_ONLY(1'b0)) u_cts (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.pin_n    (cts_n),
		.active_q (line_state[0]),
		.change   (line_chg[0])
	);
	line_change_det #(.RISE_ONLY(1'b0)) u_dsr (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.pin_n    (dsr_n),
		.active_q (line_state[1]),
		.change   (line_chg[1])
	);
	line_change_det #(.RISE_ONLY(1'b1)) u_ri (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.pin_n    (ri_n),
		.active_q (line_state[2]),
		.change   (line_chg[2])
	);
	line_change_det #(.RISE_ONLY(1'b0)) u_dcd (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.pin_n    (dcd_n),
		.active_q (line_state[3]),
		.change   (line_chg[3])
	);

	// ----------------------------------------------------------------
	// AXI4-Lite write path
	// ----------------------------------------------------------------
	always_comb begin
		do_write  = aw_full_q & w_full_q & ~bvalid;
		aw_full_d = aw_full_q;
		w_full_d  = w_full_q;
		if (do_write) begin
			aw_full_d = 1'b0;
			w_full_d  = 1'b0;
		end else begin
			if (awvalid && awready) begin
				aw_full_d = 1'b1;
			end
			if (wvalid && wready) begin
				w_full_d = 1'b1;
			end
		end
		wr_off = 8'({aw_addr_q[ADDR_W-1:2], 2'b00});
		wr_en  = do_write & w_strb0_q;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q <= 1'b0;
			w_full_q  <= 1'b0;
			awready   <= 1'b0;
			wready    <= 1'b0;
		end else begin
			aw_full_q <= aw_full_d;
			w_full_q  <= w_full_d;
			awready   <= ~aw_full_d;
			wready    <= ~w_full_d;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_addr_q <= '0;
			w_data_q  <= 32'h0000_0000;
			w_strb0_q <= 1'b0;
		end else begin
			if (awvalid && awready) begin
				aw_addr_q <= awaddr;
			end
			if (wvalid && wready) begin
				w_data_q  <= wdata;
				w_strb0_q <= wstrb[0];
			end
		end
	end

	always_comb begin
		case (wr_off)
			OFF_MODEM_LINE_STATE, OFF_SCRATCH_BYTE, OFF_ENH_FEATURE,
			OFF_LINE_CONTROL, OFF_IRQ_STATUS, OFF_IRQ_CLEAR,
			OFF_IRQ_ENABLE: wr_hit = 1'b1;
			default:        wr_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp  <= RESP_OKAY;
		end else if (do_write) begin
			bvalid <= 1'b1;
			bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Writable registers
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			scratch_q <= RST_SCRATCH;
		end else if (wr_en && wr_off == OFF_SCRATCH_BYTE) begin
			scratch_q <= w_data_q[7:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			enh_q <= RST_ENH;
		end else if (wr_en && wr_off == OFF_ENH_FEATURE) begin
			enh_q <= w_data_q[7:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			control_q <= RST_CONTROL;
			irq_en_q  <= RST_IRQ_EN;
		end else if (wr_en) begin
			if (wr_off == OFF_LINE_CONTROL) begin
				control_q <= w_data_q[2:0];
			end
			if (wr_off == OFF_IRQ_ENABLE) begin
				irq_en_q <= w_data_q[IRQ_W-1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Modem change flags
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags_q <= 4'h0;
		end else begin
			flags_q <= (flags_q & ~{4{msr_read}}) | line_chg;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			modem_irq <= 1'b0;
		end else begin
			modem_irq <= |flags_q;
		end
	end

	// ----------------------------------------------------------------
	// Flow control
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_pause <= 1'b0;
		end else if (!enh_q[EFR_AUTO_CTS_BIT]) begin
			tx_pause <= 1'b0;
		end else if (line_state[0]) begin
			tx_pause <= 1'b0;
		end else if (!tx_char_active) begin
			tx_pause <= 1'b1;
		end
	end

	rts_throttle #(
		.FIFO_DEPTH (FIFO_DEPTH),
		.LVL_W      (LVL_W)
	) u_rts (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.enable     (enh_q[EFR_AUTO_RTS_BIT]),
		.trig_sel   (control_q[CTL_TRIG_LSB +: 2]),
		.rx_level   (rx_level),
		.throttle_q (throttle_q)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rts_n <= 1'b1;
		// plain control bit when auto off
		end else if (!enh_q[EFR_AUTO_RTS_BIT]) begin
			rts_n <= ~control_q[CTL_RTS_BIT];
		end else begin
			rts_n <= throttle_q | ~control_q[CTL_RTS_BIT];
		end
	end

	always_comb begin
		trig_hit = enh_q[EFR_AUTO_RTS_BIT]
			&& 8'(rx_level) >= TRIG_LEVELS[control_q[CTL_TRIG_LSB +: 2]];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			trig_hit_q     <= 1'b0;
			rx_trigger_irq <= 1'b0;
		end else begin
			trig_hit_q     <= trig_hit;
			rx_trigger_irq <= trig_hit;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flow_select   <= 5'h00;
			dual_tx_chars <= 1'b0;
			dual_rx_chars <= 1'b0;
		end else begin
			flow_select   <= enh_q[EFR_FLOW_MSB:0];
			dual_tx_chars <= enh_q[EFR_TX_DUAL_HI] & enh_q[EFR_TX_DUAL_LO];
			dual_rx_chars <= enh_q[EFR_RX_DUAL_HI] & enh_q[EFR_RX_DUAL_LO];
		end
	end

	// ----------------------------------------------------------------
	// Interrupt status, clear and enable
	// ----------------------------------------------------------------
	always_comb begin
		irq_evt                  = '0;
		irq_evt[IRQ_MODEM_BIT]   = |line_chg;
		irq_evt[IRQ_RX_TRIG_BIT] = trig_hit & ~trig_hit_q;
		irq_clr = (wr_en && wr_off == OFF_IRQ_CLEAR) ? w_data_q[IRQ_W-1:0] : '0;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_q <= '0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_evt;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat_q & irq_en_q);
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite read path
	// ----------------------------------------------------------------
	always_comb begin
		ar_take  = arvalid & arready;
		rd_off   = 8'({araddr[ADDR_W-1:2], 2'b00});
		rd_hit   = 1'b1;
		rd_value = 32'h0000_0000;
		case (rd_off)
			OFF_MODEM_LINE_STATE: rd_value[7:0] = {line_state, flags_q};
			OFF_SCRATCH_BYTE:     rd_value[7:0] = scratch_q;
			// bit 6 reads back the auto RTS enable as written
			OFF_ENH_FEATURE:      rd_value[7:0] = enh_q;
			OFF_LINE_CONTROL:     rd_value[2:0] = control_q;
			OFF_IRQ_STATUS:       rd_value[IRQ_W-1:0] = irq_stat_q;
			OFF_IRQ_CLEAR:        rd_value = 32'h0000_0000;
			OFF_IRQ_ENABLE:       rd_value[IRQ_W-1:0] = irq_en_q;
			default:              rd_hit = 1'b0;
		endcase
		// read of modem status clears flags
		msr_read = ar_take && rd_off == OFF_MODEM_LINE_STATE;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= RESP_OKAY;
		end else if (ar_take) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rdata   <= rd_value;
			rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid) begin
			if (rready) begin
				rvalid  <= 1'b0;
				arready <= 1'b1;
			end
		end else begin
			arready <= 1'b1;
		end
	end

endmodule

`default_nettype wire

// ==== testbench/modem_flow_checker.sv ====
// Concurrent checks on the register bus, modem pins and flow control
`default_nettype none

module modem_flow_checker
	import modem_flow_pkg::*;
#(
	parameter int LVL_W = 6
) (
	// Clock and reset
	input wire logic             aclk,
	input wire logic             aresetn,
	// Register bus
	input wire logic             awvalid,
	input wire logic             awready,
	input wire logic             wvalid,
	input wire logic             wready,
	input wire logic             bvalid,
	input wire logic             arvalid,
	input wire logic             arready,
	input wire logic             rvalid,
	// Pins and flow control
	input wire logic             cts_n,
	input wire logic             dsr_n,
	input wire logic             tx_char_active,
	input wire logic             tx_pause,
	input wire logic [LVL_W-1:0] rx_level,
	input wire logic             rx_trigger_irq,
	input wire logic             modem_irq
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// ------------------------------
	// Steps
	// ------------------------------
	sequence both_taken;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence cts_low_run;
		!cts_n [*4];
	endsequence

	// ------------------------------
	// Assertions
	// ------------------------------
	wr_answer_a: assert property (both_taken |-> ##2 bvalid)
		else $error("write answer late");
	aw_refuse_a: assert property (both_taken |=> !awready && !wready)
		else $error("write slot open after take");
	rd_answer_a: assert property (arvalid && arready |=> rvalid && !arready)
		else $error("read answer late");
	ar_refuse_a: assert property (rvalid |-> !arready)
		else $error("read slot open during answer");
	dsr_change_a: assert property ($changed(dsr_n) |-> ##[3:6] modem_irq)
		else $error("dsr change not flagged");
	cts_change_a: assert property ($changed(cts_n) |-> ##[3:6] modem_irq)
		else $error("cts change not flagged");
	pause_start_a: assert property ($rose(tx_pause) |-> !$past(tx_char_active))
		else $error("pause cut a character");
	pause_release_a: assert property (cts_low_run |=> !tx_pause)
		else $error("pause held with cts low");
	rx_irq_level_a: assert property (rx_trigger_irq |-> $past(rx_level) >= TRIG_LEVELS[0])
		else $error("trigger below lowest level");
endmodule

bind modem_status_flow_control modem_flow_checker #(.LVL_W(LVL_W)) chk (.*);

`default_nettype wire

// ==== testbench/modem_peer.sv ====
// Modem-side model driving the handshake pins
`default_nettype none

module modem_peer (
	// Clock
	input  wire logic aclk,
	// Handshake pins, active low
	output var  logic cts_n,
	output var  logic dsr_n,
	output var  logic dcd_n,
	output var  logic ri_n
);
	timeunit 1ns;
	timeprecision 1ps;

	// Lines idle inactive until a scenario moves them
	initial {dcd_n, ri_n, dsr_n, cts_n} = 4'hF;

	task automatic set_lines(input logic [3:0] v);
		@(posedge aclk);
		{dcd_n, ri_n, dsr_n, cts_n} <= v;
	endtask
endmodule

`default_nettype wire

// ==== testbench/modem_status_flow_control_tb.sv ====
// Self-checking bench for the modem status and flow control block
`default_nettype none

module modem_status_flow_control_tb
	import modem_flow_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, cts_n, dsr_n, dcd_n, ri_n, rts_n;
	logic        tx_char_active, tx_pause, rx_trigger_irq, dual_tx_chars, dual_rx_chars;
	logic        modem_irq, irq;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic [5:0]  rx_level;
	logic [4:0]  flow_select;
	int          num_errors, tests_run;

	modem_status_flow_control DUT (.*);
	modem_peer peer (.*);

	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	// ------------------------------
	// Bus and compare tasks
	// ------------------------------
	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wait_clk(input int n);
		repeat (n) @(posedge aclk);
	endtask

	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			if (bvalid)
				break;
		end
		if (n == 40) begin
			num_errors++;
			print_verdict();
		end
		r = bresp;
	endtask

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
			if (rvalid)
				break;
		end
		if (n == 40) begin
			num_errors++;
			print_verdict();
		end
		d = rdata;
		r = rresp;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		axi_write(a, d, r);
		check("bresp", 32'(RESP_OKAY), 32'(r));
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
		logic [31:0] d;
		logic [1:0]  r;
		axi_read(a, d, r);
		check(what, exp, d);
	endtask

	// ------------------------------
	// Scenarios
	// ------------------------------
	task automatic t_defaults();
		logic [31:0] d;
		logic [1:0]  r;
		rd_chk(OFF_MODEM_LINE_STATE, 32'h0, "line state");
		rd_chk(OFF_SCRATCH_BYTE, 32'(RST_SCRATCH), "scratch");
		rd_chk(OFF_ENH_FEATURE, 32'(RST_ENH), "enhanced");
		check("rts_n", 32'h1, 32'(rts_n));
		axi_read(8'h1C, d, r);
		check("rresp", 32'(RESP_SLVERR), 32'(r));
		axi_write(8'h1C, 32'h5A, r);
		check("bresp", 32'(RESP_SLVERR), 32'(r));
	endtask

	task automatic t_scratch();
		wr(OFF_SCRATCH_BYTE, 32'hA5);
		rd_chk(OFF_SCRATCH_BYTE, 32'hA5, "scratch");
		wr(OFF_SCRATCH_BYTE, 32'hFFFFFF5A);
		rd_chk(OFF_SCRATCH_BYTE, 32'h5A, "scratch");
		wstrb <= 4'hE;
		wr(OFF_SCRATCH_BYTE, 32'h33);
		wstrb <= 4'hF;
		rd_chk(OFF_SCRATCH_BYTE, 32'h5A, "scratch");
	endtask

	task automatic t_modem();
		peer.set_lines(4'b1101);
		wait_clk(8);
		check("modem irq", 32'h1, 32'(modem_irq));
		check("irq masked", 32'h0, 32'(irq));
		rd_chk(OFF_MODEM_LINE_STATE, 32'h22, "line state");
		wait_clk(2);
		check("modem irq", 32'h0, 32'(modem_irq));
		rd_chk(OFF_MODEM_LINE_STATE, 32'h20, "line state");
		rd_chk(OFF_IRQ_STATUS, 32'h1, "irq status");
		wr(OFF_IRQ_CLEAR, 32'h1);
		rd_chk(OFF_IRQ_STATUS, 32'h0, "irq status");
		wr(OFF_IRQ_ENABLE, 32'h1);
		peer.set_lines(4'b1100);
		wait_clk(8);
		check("irq", 32'h1, 32'(irq));
		rd_chk(OFF_MODEM_LINE_STATE, 32'h31, "line state");
		peer.set_lines(4'b0000);
		wait_clk(8);
		rd_chk(OFF_MODEM_LINE_STATE, 32'hF8, "line state");
		peer.set_lines(4'b0100);
		wait_clk(8);
		rd_chk(OFF_MODEM_LINE_STATE, 32'hB4, "line state");
		wr(OFF_IRQ_CLEAR, 32'h1);
		wait_clk(2);
		check("irq", 32'h0, 32'(irq));
	endtask

	task automatic t_flow();
		logic [7:0] v [4] = '{8'h0F, 8'h1C, 8'h13, 8'h0A};
		foreach (v[i]) begin
			wr(OFF_ENH_FEATURE, 32'(v[i]));
			rd_chk(OFF_ENH_FEATURE, 32'(v[i]), "enhanced");
			check("flow select", 32'(v[i][4:0]), 32'(flow_select));
			check("dual tx", 32'(v[i][3] & v[i][2]), 32'(dual_tx_chars));
			check("dual rx", 32'(v[i][1] & v[i][0]), 32'(dual_rx_chars));
		end
		wr(OFF_ENH_FEATURE, 32'h0);
	endtask

	task automatic t_cts();
		peer.set_lines(4'b0101);
		wait_clk(6);
		check("tx pause", 32'h0, 32'(tx_pause));
		tx_char_active <= 1'b1;
		wr(OFF_ENH_FEATURE, 32'h80);
		wait_clk(4);
		check("tx pause", 32'h0, 32'(tx_pause));
		tx_char_active <= 1'b0;
		wait_clk(2);
		check("tx pause", 32'h1, 32'(tx_pause));
		peer.set_lines(4'b0100);
		wait_clk(5);
		check("tx pause", 32'h0, 32'(tx_pause));
		wr(OFF_ENH_FEATURE, 32'h0);
	endtask

	task automatic t_rts();
		logic [5:0] lv [6] = '{6'd7, 6'd8, 6'd15, 6'd16, 6'd1, 6'd0};
		logic       er [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
		logic       ei [6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
		wr(OFF_LINE_CONTROL, 32'h1);
		rx_level <= 6'd20;
		wait_clk(4);
		check("rts_n", 32'h0, 32'(rts_n));
		check("rx trigger", 32'h0, 32'(rx_trigger_irq));
		rx_level <= 6'd0;
		wr(OFF_ENH_FEATURE, 32'h40);
		rd_chk(OFF_ENH_FEATURE, 32'h40, "enhanced");
		for (int i = 0; i < 6; i++) begin
			rx_level <= lv[i];
			wait_clk(4);
			check("rts_n", 32'(er[i]), 32'(rts_n));
			check("rx trigger", 32'(ei[i]), 32'(rx_trigger_irq));
		end
		wr(OFF_LINE_CONTROL, 32'h0);
		wait_clk(3);
		check("rts_n", 32'h1, 32'(rts_n));
	endtask

	// ------------------------------
	// Main sequence
	// ------------------------------
	initial begin
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready, tx_char_active} = 6'h0;
		{awaddr, araddr, wdata} = 48'h0;
		wstrb = 4'hF;
		rx_level = 6'h0;
		num_errors = 0;
		tests_run = 0;
		wait_clk(4);
		aresetn <= 1'b1;
		wait_clk(1);
		t_defaults();
		t_scratch();
		t_modem();
		t_flow();
		t_cts();
		t_rts();
		print_verdict();
	end
endmodule

`default_nettype wire
